//--- logic/sbr_map.vh
// register map, field layout and divider constants of the serial rate generator
`ifndef SBR_MAP_VH
`define SBR_MAP_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define SBR_ADDR_W          4
`define SBR_RATE_SELECT     4'h0
`define SBR_RATE_STATUS     4'h1
`define SBR_RATE_SELECT_RST 8'h00

// ----------------------------------------------------------------
// field positions in serial_rate_select
// ----------------------------------------------------------------
`define SBR_PRESCALE_HI     5
`define SBR_PRESCALE_LO     4
`define SBR_RATE_HI         2
`define SBR_RATE_LO         0

// ----------------------------------------------------------------
// divider constants
// ----------------------------------------------------------------
`define SBR_FIXED_DIV       64
`define SBR_FIXED_DIV_W     6
`define SBR_PRE_DIV_1       4'h0
`define SBR_PRE_DIV_3       4'h2
`define SBR_PRE_DIV_4       4'h3
`define SBR_PRE_DIV_13      4'hC
`define SBR_PRE_W           4
`define SBR_RATE_W          7

`endif

//--- logic/sbr_prescaler.v
// prescaler stage: divides an enable stream by 1, 3, 4 or 13
`timescale 1ns/1ps
`include "sbr_map.vh"

module sbr_prescaler (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // control
    input  wire [1:0] prescale_select,
    input  wire       tick_in,
    // output
    output reg        tick_out
);

    reg  [`SBR_PRE_W-1:0] count_reg;
    reg  [`SBR_PRE_W-1:0] reload;

    // ----------------------------------------------------------------
    // divisor decode
    // ----------------------------------------------------------------
    // reload is count-1 so the counter wraps at the divisor
    always @* begin
        case (prescale_select) // R2
            2'b00:   reload = `SBR_PRE_DIV_1;
            2'b01:   reload = `SBR_PRE_DIV_3;
            2'b10:   reload = `SBR_PRE_DIV_4;
            2'b11:   reload = `SBR_PRE_DIV_13;
            default: reload = `SBR_PRE_DIV_1;
        endcase
    end

    // ----------------------------------------------------------------
    // down counter
    // ----------------------------------------------------------------
    // the new divisor is only loaded at terminal count, so a field change never glitches
    always @(posedge clock) begin
        if (rst) begin
            count_reg <= `SBR_PRE_DIV_1;
            tick_out  <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (count_reg == {`SBR_PRE_W{1'b0}}) begin
                    count_reg <= reload; // R6
                    tick_out  <= 1'b1;
                end else begin
                    count_reg <= count_reg - 4'h1;
                end
            end
        end
    end

endmodule // sbr_prescaler

//--- logic/sbr_rate_divider.v
// rate stage: divides an enable stream by a power of two from 1 to 128
`timescale 1ns/1ps
`include "sbr_map.vh"

module sbr_rate_divider (
    // clock and reset
    input  wire       clock,
    input  wire       rst,
    // control
    input  wire [2:0] rate_select,
    input  wire       tick_in,
    // output
    output reg        tick_out
);

    reg  [`SBR_RATE_W-1:0] count_reg;
    wire [`SBR_RATE_W-1:0] reload;

    // ----------------------------------------------------------------
    // divisor decode
    // ----------------------------------------------------------------
    // 2^n - 1 as reload value
    assign reload = ~({`SBR_RATE_W{1'b1}} << rate_select); // R4

    // ----------------------------------------------------------------
    // down counter
    // ----------------------------------------------------------------
    always @(posedge clock) begin
        if (rst) begin
            count_reg <= {`SBR_RATE_W{1'b0}};
            tick_out  <= 1'b0;
        end else begin
            tick_out <= 1'b0;
            if (tick_in) begin
                if (count_reg == {`SBR_RATE_W{1'b0}}) begin
                    count_reg <= reload; // R6
                    tick_out  <= 1'b1;
                end else begin
                    count_reg <= count_reg - 7'h01;
                end
            end
        end
    end

endmodule // sbr_rate_divider

//--- logic/sbr_rate_generator.v
// serial rate generator: register port plus the divider cascade
//
// Overview of operation
// R1 - One rate setting drives both receiver and transmitter through a single shared rate tick.
// R2 - Prescale select 00, 01, 10, 11 divides by 1, 3, 4 and 13.
// R3 - Reset clears the prescale select field, which stays readable and writable.
// R4 - Rate select is a power-of-two divisor from 1 to 128, read/write, cleared by reset.
// R5 - Bit rate is the input clock divided by 64 times prescale divisor times rate divisor.
// R6 - The divider is a cascade of enable-pulse counters and new settings load at reload.
//
// The register addresses and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "sbr_map.vh"

module sbr_rate_generator (
    // clock and reset
    input  wire                   clock,
    input  wire                   rst,
    // register port
    input  wire [`SBR_ADDR_W-1:0] addr,
    input  wire [7:0]             wr_data,
    input  wire                   wr_en,
    input  wire                   rd_en,
    output reg  [7:0]             rd_data,
    // rate enables
    output reg                    rx_rate_tick,
    output reg                    tx_rate_tick
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg  [7:0]                  serial_rate_select_reg;
    reg  [`SBR_FIXED_DIV_W-1:0] fixed_count_reg;
    reg                         fixed_tick_reg;
    reg  [7:0]                  tick_count_reg;
    wire                        pre_tick;
    wire                        rate_tick;
    wire [1:0]                  prescale_select;
    wire [2:0]                  rate_select;

    assign prescale_select = serial_rate_select_reg[`SBR_PRESCALE_HI:`SBR_PRESCALE_LO];
    assign rate_select     = serial_rate_select_reg[`SBR_RATE_HI:`SBR_RATE_LO];

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // unused bits are not stored so they always read zero
    always @(posedge clock) begin
        if (rst) begin
            serial_rate_select_reg <= `SBR_RATE_SELECT_RST; // R3
        end else if (wr_en && addr == `SBR_RATE_SELECT) begin
            serial_rate_select_reg <= {2'b00, wr_data[`SBR_PRESCALE_HI:`SBR_PRESCALE_LO],
                                       1'b0, wr_data[`SBR_RATE_HI:`SBR_RATE_LO]}; // R3
        end
    end

    // ----------------------------------------------------------------
    // register reads
    // ----------------------------------------------------------------
    // status word counts rate ticks so software can see the generator run
    always @(posedge clock) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (rd_en) begin
            case (addr)
                `SBR_RATE_SELECT: rd_data <= serial_rate_select_reg;
                `SBR_RATE_STATUS: rd_data <= tick_count_reg;
                default:          rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // fixed divide by 64
    // ----------------------------------------------------------------
    // free running, the variable stages after it only see its enable
    always @(posedge clock) begin
        if (rst) begin
            fixed_count_reg <= {`SBR_FIXED_DIV_W{1'b0}};
            fixed_tick_reg  <= 1'b0;
        end else begin
            fixed_count_reg <= fixed_count_reg + 6'h01; // R5
            fixed_tick_reg  <= (fixed_count_reg == 6'h3F); // R5
        end
    end

    // ----------------------------------------------------------------
    // variable stages
    // ----------------------------------------------------------------
    sbr_prescaler u_prescaler (
        .clock           (clock),
        .rst             (rst),
        .prescale_select (prescale_select),
        .tick_in         (fixed_tick_reg),
        .tick_out        (pre_tick)
    );

    sbr_rate_divider u_rate_divider (
        .clock       (clock),
        .rst         (rst),
        .rate_select (rate_select),
        .tick_in     (pre_tick),
        .tick_out    (rate_tick)
    );

    // ----------------------------------------------------------------
    // shared output
    // ----------------------------------------------------------------
    // both directions take the same registered tick, so they never drift apart
    always @(posedge clock) begin
        if (rst) begin
            rx_rate_tick   <= 1'b0;
            tx_rate_tick   <= 1'b0;
            tick_count_reg <= 8'h00;
        end else begin
            rx_rate_tick <= rate_tick; // R1
            tx_rate_tick <= rate_tick; // R1
            if (rate_tick) begin
                tick_count_reg <= tick_count_reg + 8'h01;
            end
        end
    end

endmodule // sbr_rate_generator

//--- testbench/sbr_rate_generator_sva.sv
// checker for the serial rate generator ports
`timescale 1ns/1ps
`include "sbr_map.vh"

module sbr_rate_checker (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rst,
    // register port
    input wire logic [`SBR_ADDR_W-1:0] addr,
    input wire logic [7:0]             wr_data,
    input wire logic                   wr_en,
    input wire logic                   rd_en,
    input wire logic [7:0]             rd_data,
    // rate enables
    input wire logic                   rx_rate_tick,
    input wire logic                   tx_rate_tick
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [16:0] gap_reg;
    // cycles since the last tick, saturating so a dead divider still shows up
    always_ff @(posedge clock) begin
        if (rst || rx_rate_tick) gap_reg <= 17'h00000;
        else if (gap_reg != 17'h1FFFF) gap_reg <= gap_reg + 17'h00001;
    end
    a_ticks_paired: assert property (rx_rate_tick == tx_rate_tick)
        else $error("rx and tx ticks differ");
    a_tick_single: assert property (rx_rate_tick |=> (!rx_rate_tick)[*8])
        else $error("tick longer than one cycle");
    a_gap_min: assert property (rx_rate_tick |-> gap_reg >= 17'h0003F)
        else $error("tick period below 64 cycles");
    a_gap_max: assert property (gap_reg < 17'h1A040)
        else $error("tick period above the slowest setting");
    a_field_mask: assert property (rd_en && addr == 4'h0 |=>
        rd_data[7:6] == 2'h0 && !rd_data[3])
        else $error("unused bits read as one");
    a_write_readback: assert property (wr_en && addr == 4'h0 ##1 rd_en && addr == 4'h0
        |=> rd_data == ($past(wr_data, 2) & 8'h37))
        else $error("readback differs from write");
    a_rd_idle: assert property (!rd_en |=> rd_data == 8'h00)
        else $error("read data outside read cycle");
endmodule // sbr_rate_checker

bind sbr_rate_generator sbr_rate_checker u_chk (.clock(clock), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .rx_rate_tick(rx_rate_tick), .tx_rate_tick(tx_rate_tick));

//--- testbench/tb.sv
// self-checking bench for the serial rate generator
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end

module tb;
    logic       clock = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wr_data = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    wire  [7:0] rd_data;
    wire        rx_rate_tick;
    wire        tx_rate_tick;
    int         err_count = 0;
    int         comparisons = 0;
    logic [7:0] d;
    logic [7:0] d2;
    int         n;

    sbr_rate_generator dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
        .rx_rate_tick(rx_rate_tick), .tx_rate_tick(tx_rate_tick));

    always #50 clock = ~clock;

    // ------------------------------------------------------------
    // bus and tick helpers
    // ------------------------------------------------------------
    // called right after an edge, so a read can follow a write with no gap
    task wr(input logic [3:0] a, input logic [7:0] v);
        wr_en <= 1'b1;
        addr <= a;
        wr_data <= v;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask
    // read data stand for one cycle; taken at the edge that closes that cycle
    task rd(input logic [3:0] a, output logic [7:0] v);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        @(posedge clock);
        v = rd_data;
    endtask
    // bounded wait; ticks are seen at the edge that closes their cycle
    task wait_tick(output int c);
        c = 0;
        do begin
            @(posedge clock);
            c++;
        end while (rx_rate_tick !== 1'b1 && c < 20000);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_fields;
        rd(4'h0, d);
        `CHK(d, 8'h00)
        wr(4'h0, 8'hFF);
        rd(4'h0, d);
        `CHK(d, 8'h37)
        rd(4'hF, d);
        `CHK(d, 8'h00)
    endtask
    // one full period after the change has flushed through both stages
    task t_period(input logic [7:0] s, input int exp);
        wr(4'h0, s);
        wait_tick(n);
        wait_tick(n);
        wait_tick(n);
        `CHK(n, exp)
        `CHK(tx_rate_tick, 1'b1)
        // the status count steps by one per shared tick
        rd(4'h1, d);
        wait_tick(n);
        rd(4'h1, d2);
        `CHK(d2, d + 8'h01)
    endtask
    task t_mid_reset;
        wr(4'h0, 8'h35);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        rd(4'h0, d);
        `CHK(d, 8'h00)
        rd(4'h1, d);
        `CHK(d, 8'h00)
    endtask

    task report_and_stop;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // watchdog: the planned run is about 30000 cycles
    initial begin
        #(60000 * 100);
        err_count++;
        report_and_stop;
    end

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        t_fields;
        t_period(8'h00, 64);
        t_period(8'h01, 128);
        t_period(8'h10, 192);
        t_period(8'h20, 256);
        t_period(8'h30, 832);
        t_period(8'h07, 8192);
        t_mid_reset;
        t_period(8'h00, 64);
        report_and_stop;
    end
endmodule // tb
